// File: core_timing_pkg.sv
// Shared constants and carrier types for the core timing and decode logic
package core_timing_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS = 100;

  // Data space map, byte addresses
  localparam logic [15:0] RF_END = 16'h001f;
  localparam logic [15:0] IO_START = 16'h0020;
  localparam logic [15:0] IO_END = 16'h005f;
  localparam logic [15:0] EXT_START = 16'h0060;
  localparam logic [15:0] EXT_END = 16'h00ff;
  localparam logic [15:0] RAM_START = 16'h0100;
  localparam logic [15:0] RAM_END = 16'h02ff;
  localparam logic [15:0] IO_OFFSET = 16'h0020;

  // EEPROM space: 512 bytes, 0x000 to 0x1ff
  localparam int EE_AW = 9;
  localparam logic [8:0] EE_END = 9'h1ff;

  // Values after reset
  localparam logic [15:0] SP_RESET = 16'h02ff;
  localparam logic [15:0] IP_RESET = 16'h0000;

  // Cycle counts of the sequences, and the largest displacement
  localparam int ENTRY_CYCLES = 4;
  localparam int JUMP_CYCLES = 3;
  localparam int WAKE_CYCLES = 4;
  localparam int RETURN_CYCLES = 4;
  localparam int RAM_CYCLES = 2;
  localparam int EE_RD_STALL = 4;
  localparam int EE_WR_STALL = 2;
  localparam int DISP_MAX = 63;

  // Self-timed EEPROM programming time, rounded up to whole cycles
  localparam int EE_WRITE_TIME_US = 3400;
  localparam int EE_WRITE_CYCLES_DEF =
    (EE_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    am_direct, am_disp, am_indirect, am_predec, am_postinc
  } acc_mode_t;

  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} ptr_sel_t;

  typedef enum logic [2:0]
  {
    rg_none, rg_regfile, rg_std_io, rg_ext_io, rg_internal_ram
  } region_t;

  // One data-space access request from the core
  typedef struct packed {
    logic req;
    logic we;
    logic io_short;
    acc_mode_t mode;
    ptr_sel_t ptr;
    logic [5:0] disp;
    logic [15:0] addr;
  } acc_req_t;

  // Read data returned by each data-space target
  typedef struct packed {
    logic [7:0] rf;
    logic [7:0] io;
    logic [7:0] ram;
  } rdata_t;

  // Stack port toward data SRAM
  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } stack_bus_t;

endpackage: core_timing_pkg

// File: data_space_decoder.sv
// Data-space address generation, region decode and access latency
module data_space_decoder (
  input wire logic ref_clk,
  input wire logic rst,
  input core_timing_pkg::acc_req_t acc,
  input wire logic [15:0] x_ptr,
  input wire logic [15:0] y_ptr,
  input wire logic [15:0] z_ptr,
  input core_timing_pkg::rdata_t mem_rdata,
  output core_timing_pkg::region_t region,
  output logic [15:0] eff_addr,
  output logic ptr_we,
  output core_timing_pkg::ptr_sel_t ptr_sel,
  output logic [15:0] ptr_val,
  output logic acc_done,
  output logic [7:0] rd_data
);
  import core_timing_pkg::*;

  logic [15:0] base;
  logic [15:0] ea;
  logic [15:0] upd;
  logic upd_we;
  logic busy;
  logic busy_we;

  // Region of a data address; anything past the SRAM selects nothing
  function automatic region_t region_of(input logic [15:0] a);
    if (a <= RF_END) return rg_regfile;
    if (a <= IO_END) return rg_std_io;
    if (a <= EXT_END) return rg_ext_io;
    if (a <= RAM_END) return rg_internal_ram;
    return rg_none;
  endfunction: region_of

  // Effective address and pointer update for each addressing mode
  always_comb
  begin
    unique case (acc.ptr)
      ptr_x: base = x_ptr;
      ptr_y: base = y_ptr;
      ptr_z: base = z_ptr;
      default: base = z_ptr;
    endcase
    ea = base;
    upd = base;
    upd_we = 1'h0;
    // Short I/O opcodes carry six bits, so they never reach extended I/O
    if (acc.io_short)
      ea = {10'h000, acc.addr[5:0]} + IO_OFFSET;
    else
      unique case (acc.mode)
        am_direct: ea = acc.addr;
        am_disp:
        begin
          // X has no displacement form; the offset is then ignored
          if (acc.ptr != ptr_x)
            ea = base + {10'h000, acc.disp};
        end
        am_indirect: ea = base;
        am_predec:
        begin
          ea = base - 16'h0001;
          upd = base - 16'h0001;
          upd_we = 1'h1;
        end
        am_postinc:
        begin
          upd = base + 16'h0001;
          upd_we = 1'h1;
        end
        default: ea = base;
      endcase
  end

  // Access sequencing; SRAM holds the request for a second cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      region <= rg_none;
      eff_addr <= 16'h0000;
      ptr_we <= 1'h0;
      ptr_sel <= ptr_x;
      ptr_val <= 16'h0000;
      acc_done <= 1'h0;
      rd_data <= 8'h00;
      busy <= 1'h0;
      busy_we <= 1'h0;
    end
    else
    begin
      acc_done <= 1'h0;
      ptr_we <= 1'h0;
      if (busy)
      begin
        busy <= 1'h0;
        acc_done <= 1'h1;
        rd_data <= busy_we ? 8'h00 : mem_rdata.ram;
      end
      else if (acc.req)
      begin
        region <= region_of(ea);
        eff_addr <= ea;
        ptr_we <= upd_we;
        ptr_sel <= acc.ptr;
        ptr_val <= upd;
        busy_we <= acc.we;
        if (region_of(ea) == rg_internal_ram)
          busy <= 1'h1;
        else
        begin
          acc_done <= 1'h1;
          unique case (region_of(ea))
            rg_regfile: rd_data <= acc.we ? 8'h00 : mem_rdata.rf;
            rg_std_io: rd_data <= acc.we ? 8'h00 : mem_rdata.io;
            rg_ext_io: rd_data <= acc.we ? 8'h00 : mem_rdata.io;
            default: rd_data <= 8'h00;
          endcase
        end
      end
    end
  end

  ram_two_cycle_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (acc.req && !busy && region_of(ea) == rg_internal_ram)
      |=> !acc_done ##1 acc_done)
    else $error("sram access did not take two cycles");

  unmapped_zero_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (acc_done && region == rg_none) |-> rd_data == 8'h00)
    else $error("unmapped read returned nonzero data");

endmodule: data_space_decoder

// File: eeprom_access_timer.sv
// EEPROM read and write stall timing with self-timed programming busy
module eeprom_access_timer #(
  parameter int WRITE_CYCLES = core_timing_pkg::EE_WRITE_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [core_timing_pkg::EE_AW-1:0] addr,
  output logic stall,
  output logic prog_enable,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic [core_timing_pkg::EE_AW-1:0] addr_q
);
  import core_timing_pkg::*;

  localparam int WC_W = $clog2(WRITE_CYCLES + 1);

  generate
    if (WRITE_CYCLES < 1)
      $error("WRITE_CYCLES must be at least one");
  endgenerate

  logic [2:0] stall_cnt;
  logic [2:0] next_stall_cnt;
  logic [WC_W-1:0] wr_cnt;
  logic rd_go;
  logic wr_go;

  // Requests while programming or stalled are dropped; read wins a tie
  assign rd_go = rd_req && !prog_enable && stall_cnt == 3'h0;
  assign wr_go = wr_req && !rd_req && !prog_enable && stall_cnt == 3'h0;

  // Stall length per access kind
  always_comb
  begin
    next_stall_cnt = stall_cnt;
    if (rd_go)
      next_stall_cnt = 3'(EE_RD_STALL);
    else if (wr_go)
      next_stall_cnt = 3'(EE_WR_STALL);
    else if (stall_cnt != 3'h0)
      next_stall_cnt = stall_cnt - 3'h1;
  end

  // Stall counter and core halt
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stall_cnt <= 3'h0;
      stall <= 1'h0;
    end
    else
    begin
      stall_cnt <= next_stall_cnt;
      stall <= next_stall_cnt != 3'h0;
    end
  end

  // Strobes toward the array and latched byte address
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_strobe <= 1'h0;
      wr_strobe <= 1'h0;
      addr_q <= '0;
    end
    else
    begin
      rd_strobe <= rd_go;
      wr_strobe <= wr_go;
      if (rd_go || wr_go)
        addr_q <= addr;
    end
  end

  // Programming busy holds until the self-timed write ends
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prog_enable <= 1'h0;
      wr_cnt <= '0;
    end
    else if (wr_go)
    begin
      prog_enable <= 1'h1;
      wr_cnt <= WC_W'(WRITE_CYCLES - 1);
    end
    else if (prog_enable)
    begin
      if (wr_cnt == '0)
        prog_enable <= 1'h0;
      else
        wr_cnt <= wr_cnt - 1'h1;
    end
  end

  ee_read_stall_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_go |=> stall [*4] ##1 !stall)
    else $error("eeprom read stall not four cycles");

  ee_write_stall_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_go |=> stall [*2] ##1 !stall)
    else $error("eeprom write stall not two cycles");

  ee_busy_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_go |=> prog_enable [*8])
    else $error("programming busy dropped early");

endmodule: eeprom_access_timer

// File: core_memory_and_irq_timing.sv
// Interrupt entry and return sequencer with data and EEPROM timing
// Contract
// - Interrupt entry takes four cycles to vector
// - Entry pushes instruction pointer before vector fetch
// - Vector jump takes three cycles to handler
// - Multi-cycle instruction finishes before entry begins
// - Wake from sleep adds four entry cycles
// - Return takes four cycles, pops, enables interrupts
// - Addresses up to 0x001F select register file
// - Addresses 0x0020 to 0x005F select standard I/O
// - Addresses 0x0060 to 0x00FF select extended I/O
// - Addresses 0x0100 to 0x02FF select internal SRAM
// - Short I/O opcodes reach first 64 only
// - Displacement up to 63 added to Y/Z
// - Pointer predecrements before or postincrements after access
// - Internal SRAM access completes in two cycles
// - EEPROM is separate 512-byte byte space
// - EEPROM read stalls core four cycles
// - EEPROM write start stalls core two cycles
// - EEPROM write self-timed with completion status
// - Program memory is 16-bit words by pointer
// - Instruction after enable runs before pending interrupt
// - Entry clears global interrupt enable
// - Lower vector address has higher priority
// - Entry push lowers stack pointer by two
// - Programming enable stays set while busy
module core_memory_and_irq_timing #(
  parameter int IRQ_N = 8,
  parameter int PC_W = 13,
  parameter int VECTOR_WORDS = 1,
  parameter int EE_WRITE_CYCLES = core_timing_pkg::EE_WRITE_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [IRQ_N-1:0] irq_req,
  input wire logic instr_done,
  input wire logic sei_exec,
  input wire logic cli_exec,
  input wire logic irq_return_instruction_exec,
  input wire logic sleeping,
  input wire logic wake_ready,
  input wire logic [PC_W-1:0] ip_now,
  input wire logic [15:0] prog_word,
  input wire logic [7:0] stack_rdata,
  input wire logic sp_load,
  input wire logic [15:0] sp_load_val,
  input core_timing_pkg::acc_req_t acc,
  input wire logic [15:0] x_ptr,
  input wire logic [15:0] y_ptr,
  input wire logic [15:0] z_ptr,
  input core_timing_pkg::rdata_t mem_rdata,
  input wire logic ee_rd_req,
  input wire logic ee_wr_req,
  input wire logic [core_timing_pkg::EE_AW-1:0] ee_addr,
  output logic [PC_W-1:0] instr_pointer,
  output logic ip_load,
  output logic [IRQ_N-1:0] irq_ack,
  output logic status_word_ie,
  output logic core_hold,
  output logic [15:0] stack_ptr,
  output core_timing_pkg::stack_bus_t stack_bus,
  output core_timing_pkg::region_t region,
  output logic [15:0] eff_addr,
  output logic ptr_we,
  output core_timing_pkg::ptr_sel_t ptr_sel,
  output logic [15:0] ptr_val,
  output logic acc_done,
  output logic [7:0] rd_data,
  output logic ee_stall,
  output logic eeprom_prog_enable_bit,
  output logic ee_rd_strobe,
  output logic ee_wr_strobe,
  output logic [core_timing_pkg::EE_AW-1:0] ee_addr_q
);
  import core_timing_pkg::*;

  localparam int IDX_W = $clog2(IRQ_N);

  // The relative jump offset is twelve bits, so the pointer must exceed it
  generate
    if (IRQ_N < 2 || IRQ_N > 32)
      $error("IRQ_N must lie in 2..32");
    if (PC_W < 13 || PC_W > 16)
      $error("PC_W must lie in 13..16");
    if (VECTOR_WORDS < 1 || VECTOR_WORDS > 2)
      $error("VECTOR_WORDS must be 1 or 2");
  endgenerate

  typedef enum logic [2:0]
  {
    st_run, st_wake, st_entry, st_jump, st_return
  } seq_state_t;

  seq_state_t state;
  logic [2:0] cnt;
  logic [IDX_W-1:0] vec_idx;
  logic [PC_W-1:0] vec_addr;
  logic [PC_W-1:0] saved_ip;
  logic [15:0] saved_ip16;
  logic [11:0] rel;
  logic [15:0] popped;
  logic pending;
  logic accept;
  logic wake_go;
  logic irq_return_instruction_go;
  logic take;
  logic entry_end;
  logic jump_end;
  logic ret_end;
  logic wake_end;

  // Lowest set request wins; index 0 sits right after the reset vector
  function automatic logic [IDX_W-1:0] lowest_index(
    input logic [IRQ_N-1:0] v
  );
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = IRQ_N - 1; i >= 0; i--)
      if (v[i])
        r = IDX_W'(i);
    return r;
  endfunction: lowest_index

  assign pending = |irq_req;

  // Entry is only taken at an instruction boundary, never right after an
  // enable, and a disable in the same cycle blocks it outright
  assign accept = state == st_run && instr_done && status_word_ie &&
    pending && !sleeping && !sei_exec && !cli_exec && !irq_return_instruction_exec &&
    !ee_stall;

  // A sleeping core starts waking once the clock start-up is over
  assign wake_go = state == st_run && sleeping && wake_ready &&
    status_word_ie && pending;

  assign irq_return_instruction_go = state == st_run && irq_return_instruction_exec && !accept;
  assign take = accept || wake_go;

  // Last step of each sequence
  assign wake_end = state == st_wake && cnt == 3'(WAKE_CYCLES - 1);
  assign entry_end = state == st_entry && cnt == 3'(ENTRY_CYCLES - 1);
  assign jump_end = state == st_jump && cnt == 3'(JUMP_CYCLES - 1);
  assign ret_end = state == st_return && cnt == 3'(RETURN_CYCLES - 1);
  assign saved_ip16 = 16'(saved_ip);

  // Sequencer state and step counter
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= st_run;
      cnt <= 3'h0;
    end
    else
    begin
      unique case (state)
        st_run:
        begin
          cnt <= 3'h0;
          if (wake_go)
            state <= st_wake;
          else if (accept)
            state <= st_entry;
          else if (irq_return_instruction_go)
            state <= st_return;
        end
        st_wake:
        begin
          cnt <= cnt + 3'h1;
          if (wake_end)
          begin
            state <= st_entry;
            cnt <= 3'h0;
          end
        end
        st_entry:
        begin
          cnt <= cnt + 3'h1;
          if (entry_end)
          begin
            state <= st_jump;
            cnt <= 3'h0;
          end
        end
        st_jump:
        begin
          cnt <= cnt + 3'h1;
          if (jump_end)
          begin
            state <= st_run;
            cnt <= 3'h0;
          end
        end
        st_return:
        begin
          cnt <= cnt + 3'h1;
          if (ret_end)
          begin
            state <= st_run;
            cnt <= 3'h0;
          end
        end
      endcase
    end
  end

  // Request latch, acknowledge pulse and vector address
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      vec_idx <= '0;
      vec_addr <= '0;
      saved_ip <= '0;
      irq_ack <= '0;
    end
    else
    begin
      irq_ack <= '0;
      if (take)
      begin
        vec_idx <= lowest_index(irq_req);
        vec_addr <= PC_W'((32'(lowest_index(irq_req)) + 1) * VECTOR_WORDS);
        saved_ip <= ip_now;
        irq_ack <= IRQ_N'(1) << lowest_index(irq_req);
      end
    end
  end

  // Global interrupt enable; hardware sequences override sei and cli
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      status_word_ie <= 1'h0;
    else if (take)
      status_word_ie <= 1'h0;
    else if (ret_end)
      status_word_ie <= 1'h1;
    else if (cli_exec)
      status_word_ie <= 1'h0;
    else if (sei_exec)
      status_word_ie <= 1'h1;
  end

  // Fetch hold while any sequence owns the core
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      core_hold <= 1'h0;
    else if (take || irq_return_instruction_go)
      core_hold <= 1'h1;
    else if (jump_end || ret_end)
      core_hold <= 1'h0;
  end

  // Stack pointer; the stack grows down, so a push decrements
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      stack_ptr <= SP_RESET;
    else if (state == st_entry && cnt < 3'h2)
      stack_ptr <= stack_ptr - 16'h0001;
    else if (irq_return_instruction_go || (state == st_return && cnt == 3'h0))
      stack_ptr <= stack_ptr + 16'h0001;
    else if (state == st_run && sp_load)
      stack_ptr <= sp_load_val;
  end

  // Stack port: low byte pushed first, so the high byte pops first
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      stack_bus <= '0;
    else
    begin
      stack_bus.we <= 1'h0;
      stack_bus.re <= 1'h0;
      if (state == st_entry && cnt == 3'h0)
      begin
        stack_bus.we <= 1'h1;
        stack_bus.addr <= stack_ptr;
        stack_bus.wdata <= saved_ip16[7:0];
      end
      else if (state == st_entry && cnt == 3'h1)
      begin
        stack_bus.we <= 1'h1;
        stack_bus.addr <= stack_ptr;
        stack_bus.wdata <= saved_ip16[15:8];
      end
      else if (irq_return_instruction_go || (state == st_return && cnt == 3'h0))
      begin
        stack_bus.re <= 1'h1;
        stack_bus.addr <= stack_ptr + 16'h0001;
      end
    end
  end

  // Popped return address, data valid the cycle after the read
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      popped <= 16'h0000;
    else if (state == st_return && cnt == 3'h1)
      popped[15:8] <= stack_rdata;
    else if (state == st_return && cnt == 3'h2)
      popped[7:0] <= stack_rdata;
  end

  // Jump offset from the word at the vector; only relative jumps decoded
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rel <= 12'h000;
    else if (state == st_jump && cnt == 3'h0)
      rel <= prog_word[11:0];
  end

  // Instruction pointer loads at vector, handler and return
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      instr_pointer <= PC_W'(IP_RESET);
      ip_load <= 1'h0;
    end
    else
    begin
      ip_load <= 1'h0;
      if (entry_end)
      begin
        instr_pointer <= vec_addr;
        ip_load <= 1'h1;
      end
      else if (jump_end)
      begin
        instr_pointer <= vec_addr + PC_W'(1) +
          {{(PC_W - 12){rel[11]}}, rel};
        ip_load <= 1'h1;
      end
      else if (ret_end)
      begin
        instr_pointer <= popped[PC_W-1:0];
        ip_load <= 1'h1;
      end
    end
  end

  data_space_decoder u_decoder (
    .ref_clk(ref_clk),
    .rst(rst),
    .acc(acc),
    .x_ptr(x_ptr),
    .y_ptr(y_ptr),
    .z_ptr(z_ptr),
    .mem_rdata(mem_rdata),
    .region(region),
    .eff_addr(eff_addr),
    .ptr_we(ptr_we),
    .ptr_sel(ptr_sel),
    .ptr_val(ptr_val),
    .acc_done(acc_done),
    .rd_data(rd_data)
  );

  eeprom_access_timer #(
    .WRITE_CYCLES(EE_WRITE_CYCLES)
  ) u_eeprom (
    .ref_clk(ref_clk),
    .rst(rst),
    .rd_req(ee_rd_req),
    .wr_req(ee_wr_req),
    .addr(ee_addr),
    .stall(ee_stall),
    .prog_enable(eeprom_prog_enable_bit),
    .rd_strobe(ee_rd_strobe),
    .wr_strobe(ee_wr_strobe),
    .addr_q(ee_addr_q)
  );

  default clocking sva_cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Entry occupies four cycles, then the vector load
  sequence entry_seq;
    state == st_entry [*4] ##1 ip_load;
  endsequence

  // Two pushes back to back, then the port goes quiet
  sequence push_seq;
    stack_bus.we ##1 stack_bus.we ##1 !stack_bus.we;
  endsequence

  entry_latency_a: assert property (
    accept |=> entry_seq)
    else $error("interrupt entry not four cycles");

  push_before_vector_a: assert property (
    accept |-> ##2 push_seq ##1 ip_load)
    else $error("return address not pushed before vector");

  vector_jump_a: assert property (
    entry_end |=> ##3 (ip_load && state == st_run))
    else $error("vector jump not three cycles");

  entry_boundary_a: assert property (
    $rose(state == st_entry) |-> $past(instr_done) || $past(wake_end))
    else $error("entry started inside an instruction");

  wake_latency_a: assert property (
    wake_go |=> state == st_wake [*4] ##1 entry_seq)
    else $error("wake entry not four extra cycles");

  return_seq_a: assert property (
    irq_return_instruction_go |-> ##5 (ip_load && status_word_ie &&
      stack_ptr == $past(stack_ptr, 5) + 16'h0002))
    else $error("return not four cycles with pop and enable");

  sei_shadow_a: assert property (
    (sei_exec && state == st_run) |=> state != st_entry)
    else $error("interrupt taken on enabling instruction");

  gie_clear_a: assert property (
    take |=> !status_word_ie)
    else $error("entry left interrupts enabled");

  priority_pick_a: assert property (
    take |=> $onehot(irq_ack) && (irq_ack & $past(irq_req)) != '0 &&
      ((irq_ack - 1'b1) & $past(irq_req)) == '0)
    else $error("wrong interrupt acknowledged");

  sp_push_two_a: assert property (
    accept |-> ##3 stack_ptr == $past(stack_ptr, 3) - 16'h0002)
    else $error("entry did not lower stack by two");

endmodule: core_memory_and_irq_timing

// File: mem_partner.sv
// Behavioural stack SRAM and data-space read sources
module mem_partner (
  input wire logic ref_clk,
  input core_timing_pkg::stack_bus_t stack_bus,
  output logic [7:0] stack_rdata = 8'h5a,
  output core_timing_pkg::rdata_t mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import core_timing_pkg::*;
  logic [7:0] ram [0:767];
  // Stack bytes, read data shown the cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (stack_bus.we)
      ram[stack_bus.addr] <= stack_bus.wdata;
    // Idle cycles show the inverse of the last value, so a stale byte shows again every second idle cycle
    stack_rdata <= stack_bus.re ? ram[stack_bus.addr] : ~stack_rdata;
  end
  // Fixed byte per target
  assign mem_rdata = '{rf: 8'h11, io: 8'h22, ram: 8'h33};
endmodule: mem_partner

// File: core_memory_and_irq_timing_test.sv
// Self-checking bench for interrupt sequencing and access timing
module core_memory_and_irq_timing_test;
  timeunit 1ns;
  timeprecision 100ps;
  import core_timing_pkg::*;
  logic ref_clk = 0, rst = 1, instr_done = 0, sei_exec = 0, cli_exec = 0;
  logic irq_return_instruction_exec = 0, sleeping = 0, wake_ready = 0, sp_load = 0;
  logic ee_rd_req = 0, ee_wr_req = 0, ip_load, status_word_ie, core_hold;
  logic ptr_we, acc_done, ee_stall, eeprom_prog_enable_bit, ie1;
  logic ee_rd_strobe, ee_wr_strobe;
  logic [7:0] irq_req = 0, irq_ack, stack_rdata, rd_data, ack1;
  logic [12:0] ip_now = 0, instr_pointer;
  logic [15:0] prog_word = 0, sp_load_val = 0, x_ptr = 0, y_ptr = 0;
  logic [15:0] z_ptr = 0, stack_ptr, eff_addr, ptr_val;
  logic [15:0] corner [8] = '{16'h001f, 16'h0020, 16'h005f, 16'h0060,
    16'h00ff, 16'h0100, 16'h02ff, 16'h0300};
  logic [8:0] ee_addr = 0, ee_addr_q;
  acc_req_t acc = '0;
  rdata_t mem_rdata;
  stack_bus_t stack_bus;
  region_t region;
  ptr_sel_t ptr_sel;
  int err_count = 0, n_tests = 0, n;

  // Core clock, 100 ns period
  always #50 ref_clk = ~ref_clk;

  core_memory_and_irq_timing #(.EE_WRITE_CYCLES(20)) dut (.*);
  mem_partner model (.ref_clk(ref_clk), .stack_bus(stack_bus),
    .stack_rdata(stack_rdata), .mem_rdata(mem_rdata));

  task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask: chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask: report_and_stop

  // Inputs move a fixed 5 ns after the edge, outputs settled by then
  task automatic step();
    @(posedge ref_clk);
    #5;
  endtask: step

  function automatic region_t exp_region(logic [15:0] a);
    return a < 16'h0020 ? rg_regfile : a < 16'h0060 ? rg_std_io :
      a < 16'h0100 ? rg_ext_io : a < 16'h0300 ? rg_internal_ram : rg_none;
  endfunction: exp_region

  // Pointer change expected from the addressing mode
  function automatic logic [15:0] ptr_step(acc_mode_t m);
    return m == am_postinc ? 16'h0001 :
      m == am_predec ? 16'hffff : 16'h0000;
  endfunction: ptr_step

  // Edges until the pointer loads; request pulses drop after the first
  task automatic wait_ip();
    n = 0;
    do
    begin
      step();
      n++;
      if (n == 1)
      begin
        ack1 = irq_ack;
        ie1 = status_word_ie;
        {instr_done, sei_exec, irq_return_instruction_exec, irq_req} = '0;
      end
    end while (ip_load !== 1'b1 && n < 30);
    if (n == 30)
    begin
      err_count++;
      report_and_stop();
    end
  endtask: wait_ip

  // Cycles a level stays high, bounded
  task automatic count_high(bit busy);
    n = 0;
    while ((busy ? eeprom_prog_enable_bit : ee_stall) === 1'b1 && n < 40)
    begin
      n++;
      step();
    end
    if (n == 40)
    begin
      err_count++;
      report_and_stop();
    end
  endtask: count_high

  task automatic access(acc_mode_t m, logic [15:0] a, logic [15:0] ea,
    bit io = 0);
    acc = '{1'b1, 1'b0, io, m, ptr_y, 6'h3f, a};
    step();
    acc.req = 1'b0;
    chk("eff_addr", eff_addr, ea);
    chk("region", region, exp_region(ea));
    chk("ptr_we", ptr_we, m inside {am_predec, am_postinc});
    chk("ptr_val", ptr_val, y_ptr + ptr_step(m));
    chk("done1", acc_done, exp_region(ea) != rg_internal_ram);
    if (exp_region(ea) == rg_none)
      chk("none_rd", rd_data, 0);
    else if (exp_region(ea) == rg_regfile)
      chk("rf_rd", rd_data, 8'h11);
    else if (exp_region(ea) != rg_internal_ram)
      chk("io_rd", rd_data, 8'h22);
    step();
    if (exp_region(ea) == rg_internal_ram)
    begin
      chk("ram_done", acc_done, 1);
      chk("ram_rd", rd_data, 8'h33);
    end
    step();
  endtask: access

  initial
  begin
    void'($urandom(14982));
    repeat (3) step();
    rst = 0;
    // Region edges, then random displaced, pre-decremented, post-incremented and short I/O accesses
    foreach (corner[i]) access(am_direct, corner[i], corner[i]);
    repeat (20)
    begin
      y_ptr = 16'($urandom_range(16'h0340));
      {x_ptr, z_ptr} = $urandom;
      access(am_disp, 0, y_ptr + 16'd63);
    end
    access(am_predec, 0, y_ptr - 16'd1);
    access(am_postinc, 0, y_ptr);
    access(am_direct, 16'h00ff, 16'h005f, 1);
    // EEPROM read then write at the top address
    ee_addr = 9'h1ff;
    ee_rd_req = 1;
    step();
    ee_rd_req = 0;
    chk("ee_addr_q", ee_addr_q, 9'h1ff);
    chk("rd_strobe", ee_rd_strobe, 1);
    count_high(0);
    chk("rd_stall", n, 4);
    ee_wr_req = 1;
    step();
    ee_wr_req = 0;
    chk("wr_strobe", ee_wr_strobe, 1);
    count_high(0);
    chk("wr_stall", n, 2);
    count_high(1);
    chk("busy", n, 18);
    // Entry: two pending, enable in the same cycle as completion
    prog_word = 16'h0ff0;
    ip_now = 13'h0abc;
    irq_req = 8'h0c;
    sei_exec = 1;
    instr_done = 1;
    step();
    sei_exec = 0;
    chk("ack_sei", irq_ack, 0);
    wait_ip();
    chk("entry", n, 5);
    chk("ack", ack1, 8'h04);
    chk("ie_off", ie1, 0);
    chk("vector", instr_pointer, 3);
    chk("sp_push", stack_ptr, 16'h02fd);
    chk("hold", core_hold, 1);
    wait_ip();
    chk("jump", n, 3);
    chk("hold_off", core_hold, 0);
    chk("handler", instr_pointer, 13'h1ff4);
    // Return pops the saved pointer and re-enables
    irq_return_instruction_exec = 1;
    wait_ip();
    chk("ret", n, 5);
    chk("popped", instr_pointer, 13'h0abc);
    chk("ie_on", status_word_ie, 1);
    chk("sp_pop", stack_ptr, 16'h02ff);
    // Wake from sleep on the top-priority request
    sleeping = 1;
    wake_ready = 1;
    irq_req = 8'h01;
    wait_ip();
    chk("wake", n, 9);
    chk("wake_vec", instr_pointer, 1);
    report_and_stop();
  end
endmodule: core_memory_and_irq_timing_test
